/* File: verilog/vfo_pkg.sv */
// shared constants, types and the organization decode function for the video fifo organizer
package vfo_pkg;

    localparam int ADDR_W  = 24;
    localparam int LANE_W  = 12;
    localparam int REG_AW  = 8;
    localparam int FIFO_DEPTH = 16;

    // organization select codes, x marks a don't-care bit
    localparam logic [3:0] ORG_S8  = 4'h0;
    localparam logic [3:0] ORG_S10 = 4'h2;
    localparam logic [3:0] ORG_S12 = 4'h3;
    localparam logic [3:0] ORG_S16 = 4'h8;
    localparam logic [3:0] ORG_S20 = 4'hA;
    localparam logic [3:0] ORG_S24 = 4'hB;
    localparam logic [3:0] ORG_D8  = 4'hC;
    localparam logic [3:0] ORG_D10 = 4'hE;
    localparam logic [3:0] ORG_D12 = 4'hF;

    // depths in words: 1,940,400 / 1,552,320 / 1,293,600
    localparam logic [23:0] DEPTH_1940400 = 24'h1D9BB0;
    localparam logic [23:0] DEPTH_1552320 = 24'h17AFC0;
    localparam logic [23:0] DEPTH_1293600 = 24'h13BD20;
    // 970,200 / 776,160 / 646,800
    localparam logic [23:0] DEPTH_970200  = 24'h0ECDD8;
    localparam logic [23:0] DEPTH_776160  = 24'h0BD7E0;
    localparam logic [23:0] DEPTH_646800  = 24'h09DE90;

    localparam logic [11:0] MASK_8  = 12'hFF0;
    localparam logic [11:0] MASK_10 = 12'hFFC;
    localparam logic [11:0] MASK_12 = 12'hFFF;
    localparam logic [11:0] MASK_0  = 12'h000;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DEPTH  = 8'h08;
    localparam logic [7:0] REG_WPTR0  = 8'h0C;
    localparam logic [7:0] REG_RPTR0  = 8'h10;
    localparam logic [7:0] REG_WPTR1  = 8'h14;
    localparam logic [7:0] REG_RPTR1  = 8'h18;

    localparam int CTRL_WR_EN  = 0;
    localparam int CTRL_RD_EN  = 1;
    localparam int CTRL_WR_CLR = 2;
    localparam int CTRL_RD_CLR = 3;
    localparam logic CTRL_WR_EN_RESET = 1'h1;
    localparam logic CTRL_RD_EN_RESET = 1'h1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        WIDTH_8  = 3'h0,
        WIDTH_10 = 3'h1,
        WIDTH_12 = 3'h2,
        WIDTH_16 = 3'h3,
        WIDTH_20 = 3'h4,
        WIDTH_24 = 3'h5
    } vfo_width_t;

    typedef struct packed {
        logic        dual;
        vfo_width_t  width;
        logic [23:0] depth;
    } vfo_org_t;

    typedef struct packed {
        logic [1:0]  sel;
        logic [11:0] laneOne;
        logic [11:0] laneZero;
    } vfo_word_t;

    function automatic vfo_org_t orgDecode(input logic [3:0] sel);
        vfo_org_t o;
        o = '{dual: 1'b0, width: WIDTH_8, depth: DEPTH_1940400};
        casez (sel)
            4'b000?: o = '{1'b0, WIDTH_8,  DEPTH_1940400};
            ORG_S10: o = '{1'b0, WIDTH_10, DEPTH_1552320};
            ORG_S12: o = '{1'b0, WIDTH_12, DEPTH_1293600};
            4'b100?: o = '{1'b0, WIDTH_16, DEPTH_970200};
            ORG_S20: o = '{1'b0, WIDTH_20, DEPTH_776160};
            ORG_S24: o = '{1'b0, WIDTH_24, DEPTH_646800};
            4'b110?: o = '{1'b1, WIDTH_8,  DEPTH_970200};
            ORG_D10: o = '{1'b1, WIDTH_10, DEPTH_776160};
            ORG_D12: o = '{1'b1, WIDTH_12, DEPTH_646800};
            default: o = '{1'b0, WIDTH_8,  DEPTH_1940400};
        endcase
        return o;
    endfunction

endpackage

/* File: verilog/vfo_stream_fifo.sv */
// small valid/ready fifo that sits in the write data path
module vfo_stream_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rstSyncN,
    input  wire logic             inValid,
    output      logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    output      logic             outValid,
    input  wire logic             outReady,
    output      logic [WIDTH-1:0] outData,
    output      logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      head;
    logic [AW:0]      tail;
    wire              push;
    wire              pop;
    wire              full;
    wire              empty;

    assign full     = (head[AW] != tail[AW]) && (head[AW-1:0] == tail[AW-1:0]);
    assign empty    = (head == tail);
    assign inReady  = !full;
    assign outValid = !empty;
    assign push     = inValid && !full;
    assign pop      = outReady && !empty;
    assign outData  = store[tail[AW-1:0]];
    assign count    = head - tail;

    always_ff @(posedge core_clk) begin
        if (push) begin
            store[head[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            head <= '0;
            tail <= '0;
        end else begin
            head <= head + (AW+1)'(push);
            tail <= tail + (AW+1)'(pop);
        end
    end
endmodule

/* File: verilog/vfo_top.sv */
// video frame fifo: organization decode, pointer override, register slave
//
// Overview of operation
// - select 000x gives single 8-bit, 1,940,400 deep
// - select 0010 gives single 10-bit, 1,552,320 deep
// - select 0011 gives single 12-bit, 1,293,600 deep
// - select 100x gives single 16-bit, 970,200 deep
// - select 1010 gives single 20-bit, 776,160 deep
// - select 1011 gives single 24-bit, 646,800 deep
// - select 110x gives two 8-bit, 970,200 deep
// - select 1110 gives two 10-bit, 776,160 deep
// - select 1111 gives two 12-bit, 646,800 deep
// - target 0: write load low forces write pointer
// - target 1: read load low forces read pointer
// - address override only in single-channel organizations
// - after load release, count on from forced address
// - dual channels share one read clock
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
module vfo_top #(
    parameter int MEM_WORDS = 1940400,
    parameter int FIFO_DEPTH = vfo_pkg::FIFO_DEPTH
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [3:0]          orgSelect,
    input  wire logic                overrideTargetSelect,
    input  wire logic                writePointerLoadN,
    input  wire logic                readPointerLoadN,
    input  wire logic [23:0]         extAddress,
    input  wire logic                wrValid,
    output      logic                wrReady,
    input  wire vfo_pkg::vfo_word_t  wrWord,
    input  wire logic [1:0]          rdEn,
    output      logic [1:0]          rdValid,
    output      logic [11:0]         rdLaneZeroData,
    output      logic [11:0]         rdLaneOneData,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output      logic [1:0]          s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output      logic [31:0]         s_axi_rdata,
    output      logic [1:0]          s_axi_rresp
);
    import vfo_pkg::*;

    localparam int IDX_W = $clog2(MEM_WORDS);
    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

    function automatic logic [11:0] laneMask(input vfo_width_t w,
                                             input logic upper,
                                             input logic dual);
        logic [11:0] m;
        m = MASK_0;
        case (w)
            WIDTH_8, WIDTH_16:  m = MASK_8;
            WIDTH_10, WIDTH_20: m = MASK_10;
            default:            m = MASK_12;
        endcase
        // narrow single-channel words leave lane one unused
        if (upper && !dual && (w == WIDTH_8 || w == WIDTH_10 ||
                               w == WIDTH_12)) begin
            m = MASK_0;
        end
        return m;
    endfunction

    function automatic logic [23:0] stepAddr(input logic [23:0] a,
                                             input logic [23:0] depth);
        logic [23:0] n;
        n = a + 24'h000001;
        return (n >= depth) ? 24'h000000 : n;
    endfunction

    logic [1:0]  rstPipe;
    wire         rstSyncN;
    logic [3:0]  orgMeta;
    logic [3:0]  orgSync;
    logic [3:0]  orgPrev;
    logic        ovtMeta;
    logic        ovtSync;

    // reset is released through two flops, asserted at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    // static strap pins still pass two flops before use
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            orgMeta <= 4'h0;
            orgSync <= 4'h0;
            orgPrev <= 4'h0;
            ovtMeta <= 1'b0;
            ovtSync <= 1'b0;
        end else begin
            orgMeta <= orgSelect;
            orgSync <= orgMeta;
            orgPrev <= orgSync;
            ovtMeta <= overrideTargetSelect;
            ovtSync <= ovtMeta;
        end
    end

    vfo_org_t org;
    wire         dual;
    wire [11:0]  mask0;
    wire [11:0]  mask1;
    wire         modeChanged;

    assign org   = orgDecode(orgSync);
    assign dual  = org.dual;
    assign mask0 = laneMask(org.width, 1'b0, dual);
    assign mask1 = laneMask(org.width, 1'b1, dual);
    assign modeChanged = (orgSync != orgPrev);

    logic        writeEnable;
    logic        readEnable;
    wire         wrClr;
    wire         rdClr;

    vfo_word_t   fifoWord;
    wire         fifoValid;
    wire [CNT_W-1:0] fifoCount;

    // writes stall while disabled, so the fifo fills and wrReady drops
    vfo_stream_fifo #(
        .WIDTH ($bits(vfo_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rstSyncN (rstSyncN),
        .inValid  (wrValid),
        .inReady  (wrReady),
        .inData   (wrWord),
        .outValid (fifoValid),
        .outReady (writeEnable),
        .outData  (fifoWord),
        .count    (fifoCount)
    );

    logic [23:0] wPtr0;
    logic [23:0] wPtr1;
    logic [23:0] rPtr0;
    logic [23:0] rPtr1;
    wire  [23:0] extIn;
    wire         wForce;
    wire         rForce;
    wire  [23:0] wAcc0;
    wire  [23:0] rAcc0;
    wire         pop;
    wire         wrCh0;
    wire         wrCh1;
    wire         rdCh0;
    wire         rdCh1;
    wire  [23:0] hiWrIdx;
    wire  [23:0] hiRdIdx;
    wire         hiWr;
    wire         hiRd;

    // an address past the organization's depth wraps to zero
    assign extIn  = (extAddress >= org.depth) ? 24'h000000 : extAddress;
    assign wForce = !dual && !ovtSync && !writePointerLoadN;
    assign rForce = !dual && ovtSync && !readPointerLoadN;
    assign wAcc0  = wForce ? extIn : wPtr0;
    assign rAcc0  = rForce ? extIn : rPtr0;

    assign pop   = fifoValid && writeEnable;
    assign wrCh0 = pop && (!dual || fifoWord.sel[0]);
    assign wrCh1 = pop && dual && fifoWord.sel[1];
    // both channels answer strobes on the same core clock edge
    assign rdCh0 = readEnable && rdEn[0];
    assign rdCh1 = readEnable && dual && rdEn[1];

    // lane one storage belongs to channel one in dual mode
    assign hiWrIdx = dual ? wPtr1 : wAcc0;
    assign hiRdIdx = dual ? rPtr1 : rAcc0;
    assign hiWr    = dual ? wrCh1 : wrCh0;
    assign hiRd    = dual ? rdCh1 : rdCh0;

    logic [11:0] memLo [MEM_WORDS];
    logic [11:0] memHi [MEM_WORDS];

    always_ff @(posedge core_clk) begin
        if (wrCh0) begin
            memLo[wAcc0[IDX_W-1:0]] <= fifoWord.laneZero & mask0;
        end
        if (hiWr) begin
            memHi[hiWrIdx[IDX_W-1:0]] <= fifoWord.laneOne & mask1;
        end
    end

    // a read of the address being written returns the old word
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdValid        <= 2'h0;
            rdLaneZeroData <= 12'h000;
            rdLaneOneData  <= 12'h000;
        end else begin
            rdValid <= {rdCh1, rdCh0};
            if (rdCh0) begin
                rdLaneZeroData <= memLo[rAcc0[IDX_W-1:0]] & mask0;
            end
            if (hiRd) begin
                rdLaneOneData <= memHi[hiRdIdx[IDX_W-1:0]] & mask1;
            end
        end
    end

    // an access under override steps on from the forced address
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wPtr0 <= 24'h000000;
            wPtr1 <= 24'h000000;
        end else if (wrClr || modeChanged) begin
            wPtr0 <= 24'h000000;
            wPtr1 <= 24'h000000;
        end else begin
            if (wrCh0) begin
                wPtr0 <= stepAddr(wAcc0, org.depth);
            end else if (wForce) begin
                wPtr0 <= extIn;
            end
            if (wrCh1) begin
                wPtr1 <= stepAddr(wPtr1, org.depth);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rPtr0 <= 24'h000000;
            rPtr1 <= 24'h000000;
        end else if (rdClr || modeChanged) begin
            rPtr0 <= 24'h000000;
            rPtr1 <= 24'h000000;
        end else begin
            if (rdCh0) begin
                rPtr0 <= stepAddr(rAcc0, org.depth);
            end else if (rForce) begin
                rPtr0 <= extIn;
            end
            if (rdCh1) begin
                rPtr1 <= stepAddr(rPtr1, org.depth);
            end
        end
    end

    // axi4-lite slave: address and data may arrive in either order
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0]  wStrbHeld;
    wire         doWrite;
    wire         ctrlHit;
    wire         wrMapped;
    wire         rdMapped;
    logic [31:0] rdMux;

    assign s_axi_awready = !awHeld;
    assign s_axi_wready  = !wHeld;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite  = awHeld && wHeld && !s_axi_bvalid;
    assign ctrlHit  = doWrite && (awAddrHeld == REG_CTRL) && wStrbHeld[0];
    assign wrClr    = ctrlHit && wDataHeld[CTRL_WR_CLR];
    assign rdClr    = ctrlHit && wDataHeld[CTRL_RD_CLR];
    assign wrMapped = (awAddrHeld == REG_CTRL);
    assign rdMapped = (s_axi_araddr == REG_CTRL) ||
                      (s_axi_araddr == REG_STATUS) ||
                      (s_axi_araddr == REG_DEPTH) ||
                      (s_axi_araddr == REG_WPTR0) ||
                      (s_axi_araddr == REG_RPTR0) ||
                      (s_axi_araddr == REG_WPTR1) ||
                      (s_axi_araddr == REG_RPTR1);

    always_comb begin
        if (s_axi_araddr == REG_CTRL) begin
            rdMux = {30'h0, readEnable, writeEnable};
        end else if (s_axi_araddr == REG_STATUS) begin
            rdMux = {17'h0, (5)'(fifoCount), !wrReady, ovtSync,
                     orgSync, org.width, dual};
        end else if (s_axi_araddr == REG_DEPTH) begin
            rdMux = {8'h00, org.depth};
        end else if (s_axi_araddr == REG_WPTR0) begin
            rdMux = {8'h00, wPtr0};
        end else if (s_axi_araddr == REG_RPTR0) begin
            rdMux = {8'h00, rPtr0};
        end else if (s_axi_araddr == REG_WPTR1) begin
            rdMux = {8'h00, wPtr1};
        end else if (s_axi_araddr == REG_RPTR1) begin
            rdMux = {8'h00, rPtr1};
        end else begin
            rdMux = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddrHeld   <= 8'h00;
            wDataHeld    <= 32'h00000000;
            wStrbHeld    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld     <= 1'b1;
                awAddrHeld <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld     <= 1'b1;
                wDataHeld <= s_axi_wdata;
                wStrbHeld <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            writeEnable <= CTRL_WR_EN_RESET;
            readEnable  <= CTRL_RD_EN_RESET;
        end else if (ctrlHit) begin
            writeEnable <= wDataHeld[CTRL_WR_EN];
            readEnable  <= wDataHeld[CTRL_RD_EN];
        end
    end

    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: test/vfo_top_checker.sv */
// concurrent checks on lane packing and channel reads of the organizer
module vfo_top_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  orgSelect,
    input wire logic [1:0]  rdEn,
    input wire logic [1:0]  rdValid,
    input wire logic [11:0] rdLaneZeroData,
    input wire logic [11:0] rdLaneOneData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] orgPrev;
    logic [2:0] orgAge;
    // the strap crosses two sync flops, so lanes are judged once it has aged
    wire        settled = orgAge == 3'h7;
    wire        dualOrg = orgSelect[3:2] == 2'b11;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) orgPrev <= 4'h0;
        else orgPrev <= orgSelect;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) orgAge <= 3'h0;
        else if (orgPrev != orgSelect) orgAge <= 3'h0;
        else if (!settled) orgAge <= orgAge + 3'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence rd0_s(c);
        settled && c && rdEn[0] ##1 rdValid[0];
    endsequence
    sequence rd1_s(c);
        settled && c && rdEn[1] ##1 rdValid[1];
    endsequence
    narrow_lane_one_a:
        assert property (rd0_s(!orgSelect[3]) |-> rdLaneOneData == 12'h000)
        else $error("lane one not idle for narrow word");
    s8_pack_a:
        assert property (rd0_s(orgSelect[3:1] == 3'b000)
            |-> rdLaneZeroData[3:0] == 4'h0) else $error("8-bit packing");
    s10_pack_a:
        assert property (rd0_s(orgSelect == 4'h2)
            |-> rdLaneZeroData[1:0] == 2'h0) else $error("10-bit packing");
    s16_pack_a:
        assert property (rd0_s(orgSelect[3:1] == 3'b100)
            |-> (rdLaneZeroData[3:0] | rdLaneOneData[3:0]) == 4'h0)
        else $error("16-bit packing");
    s20_pack_a:
        assert property (rd0_s(orgSelect == 4'hA)
            |-> (rdLaneZeroData[1:0] | rdLaneOneData[1:0]) == 2'h0)
        else $error("20-bit packing");
    d8_pack_a:
        assert property (rd1_s(orgSelect[3:1] == 3'b110)
            |-> rdLaneOneData[3:0] == 4'h0) else $error("dual 8-bit packing");
    ch1_dual_only_a:
        assert property (settled && rdValid[1] |-> dualOrg)
        else $error("second channel read outside dual mode");
    shared_read_a:
        assert property (rd0_s(dualOrg && rdEn[1]) |-> rdValid[1])
        else $error("channels not read on the common clock");
endmodule

/* File: test/vfo_video_source.sv */
// video source model driving the write stream of the organizer
module vfo_video_source (
    input  wire logic               core_clk,
    input  wire logic               wrReady,
    output      vfo_pkg::vfo_word_t wrWord,
    output      logic               wrValid
);
    timeunit 1ns;
    timeprecision 1ps;
    import vfo_pkg::*;
    initial begin
        wrValid = 1'b0;
        wrWord = '0;
    end
    // waits gap cycles, holds the word until taken; gives up after 20
    // cycles so that a refusal by a full buffer can be seen
    task automatic send(input vfo_word_t w, input int gap, output bit taken);
        int n;
        begin
            n = 0;
            repeat (gap) @(posedge core_clk);
            wrValid <= 1'b1;
            wrWord <= w;
            do begin
                @(posedge core_clk);
                n++;
                taken = wrReady;
            end while (!taken && n < 20);
        end
    endtask
    // released lanes show inverted data so a stale word never passes
    task automatic idle();
        wrValid <= 1'b0;
        wrWord <= ~wrWord;
    endtask
endmodule

/* File: test/tb_vfo_top.sv */
// self-checking bench for the video fifo organizer top
module tb_vfo_top;
    timeunit 1ns;
    timeprecision 1ps;
    import vfo_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
    logic        core_clk, rst_n, overrideTargetSelect, wrValid, wrReady;
    logic        writePointerLoadN, readPointerLoadN, taken;
    logic [3:0]  orgSelect, s_axi_wstrb;
    logic [23:0] extAddress, a;
    logic [1:0]  rdEn, rdValid, s_axi_bresp, s_axi_rresp, resp;
    logic [11:0] rdLaneZeroData, rdLaneOneData, m, lo;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
    logic [3:0]  codes [12];
    vfo_word_t   wrWord, w, w2;
    vfo_org_t    eo;
    int          n_fail, checked;

    vfo_top #(.MEM_WORDS(4096)) dut (.*);
    vfo_video_source src (.core_clk(core_clk), .wrReady(wrReady),
        .wrWord(wrWord), .wrValid(wrValid));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // depths 1,940,400 1,552,320 1,293,600 970,200 776,160 646,800
    function automatic vfo_org_t expOrg(input logic [3:0] s);
        casez (s)
            4'b000?: return '{1'b0, WIDTH_8, 24'h1D9BB0};
            4'b0010: return '{1'b0, WIDTH_10, 24'h17AFC0};
            4'b0011: return '{1'b0, WIDTH_12, 24'h13BD20};
            4'b100?: return '{1'b0, WIDTH_16, 24'h0ECDD8};
            4'b1010: return '{1'b0, WIDTH_20, 24'h0BD7E0};
            4'b1011: return '{1'b0, WIDTH_24, 24'h09DE90};
            4'b110?: return '{1'b1, WIDTH_8, 24'h0ECDD8};
            4'b1110: return '{1'b1, WIDTH_10, 24'h0BD7E0};
            default: return '{1'b1, WIDTH_12, 24'h09DE90};
        endcase
    endfunction
    function automatic logic [11:0] laneMask(input vfo_width_t wd);
        if (wd == WIDTH_8 || wd == WIDTH_16) return 12'hFF0;
        if (wd == WIDTH_10 || wd == WIDTH_20) return 12'hFFC;
        return 12'hFFF;
    endfunction

    task automatic axiWr(input logic [7:0] adr, input logic [31:0] v);
        @(posedge core_clk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= adr;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [7:0] adr);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= adr;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // strap passes a synchroniser, so give it time before any traffic
    task automatic setOrg(input logic [3:0] s);
        @(posedge core_clk);
        orgSelect <= s;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic rdWord(input logic [1:0] en);
        @(posedge core_clk);
        rdEn <= en;
        @(posedge core_clk);
        rdEn <= 2'b00;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        orgSelect = 4'h0;
        overrideTargetSelect = 1'b0;
        {writePointerLoadN, readPointerLoadN} = 2'b11;
        extAddress = 24'h0;
        rdEn = 2'b00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        seed = 32'h0001_0648;
        codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
                  4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        axiRd(REG_CTRL);
        `CHK(d, 32'h0000_0003)
        // dual modes hold the write override active; it must be ignored
        foreach (codes[i]) begin
            eo = expOrg(codes[i]);
            seed = lfsr(seed);
            writePointerLoadN <= !eo.dual;
            extAddress <= {12'h000, seed[31:20]} | 24'h1;
            setOrg(codes[i]);
            axiRd(REG_STATUS);
            `CHK(d[7:0], {codes[i], eo.width, eo.dual})
            axiRd(REG_DEPTH);
            `CHK(d[23:0], eo.depth)
            seed = lfsr(seed);
            w = {2'b11, seed[23:0]};
            src.send(w, i % 3, taken);
            src.idle();
            repeat (4) @(posedge core_clk);
            m = laneMask(eo.width);
            lo = (eo.dual || eo.width > WIDTH_12) ? w.laneOne & m : 12'h0;
            rdWord({eo.dual, 1'b1});
            `CHK(rdValid, {eo.dual, 1'b1})
            `CHK(rdLaneZeroData, w.laneZero & m)
            `CHK(rdLaneOneData, lo)
        end
        seed = lfsr(seed);
        a = {14'h0, seed[9:0]} | 24'h010;
        extAddress <= a;
        writePointerLoadN <= 1'b0;
        setOrg(ORG_S12);
        w2 = {2'b00, seed[31:8]};
        w = ~w2;
        src.send(w, 0, taken);
        src.idle();
        writePointerLoadN <= 1'b1;
        src.send(w2, 1, taken);
        src.idle();
        overrideTargetSelect <= 1'b1;
        readPointerLoadN <= 1'b0;
        repeat (6) @(posedge core_clk);
        rdWord(2'b01);
        `CHK(rdLaneZeroData, w.laneZero)
        readPointerLoadN <= 1'b1;
        rdWord(2'b01);
        `CHK(rdLaneZeroData, w2.laneZero)
        // stall the drain so the buffer fills until it refuses
        axiWr(REG_CTRL, 32'h0000_0002);
        `CHK(resp, RESP_OKAY)
        for (int k = 0; k < 17; k++) begin
            seed = lfsr(seed);
            src.send({2'b01, seed[23:0]}, 0, taken);
            `CHK(taken, k < 16)
        end
        src.idle();
        axiRd(REG_STATUS);
        `CHK(d[14:9], 6'h21)
        axiWr(REG_CTRL, 32'h0000_0003);
        repeat (24) @(posedge core_clk);
        axiRd(REG_STATUS);
        `CHK(d[14:9], 6'h00)
        axiRd(REG_WPTR0);
        `CHK(d[23:0], a + 24'h12)
        axiWr(REG_CTRL, 32'hF);
        axiRd(REG_WPTR0);
        `CHK(d, 32'h0)
        axiRd(8'h40);
        `CHK({resp, d}, {RESP_SLVERR, 32'h0})
        axiWr(REG_DEPTH, 32'hFFFF_FFFF);
        `CHK(resp, RESP_SLVERR)
        report_and_stop();
    end
endmodule

bind vfo_top vfo_top_checker chk (
    .core_clk(core_clk), .rst_n(rst_n), .orgSelect(orgSelect),
    .rdEn(rdEn), .rdValid(rdValid), .rdLaneZeroData(rdLaneZeroData),
    .rdLaneOneData(rdLaneOneData)
);
